// ### logic/report_sched_pkg.sv
/*
 * Constants and carrier types for the report scheduler of a satellite
 * navigation receiver's control port. Assumes one 40 MHz clock and an
 * APB master that owns the option and control registers.
 */
// Functional notes
// - Automatic reports go out without any prior command from the host.
// - Time report every 150 s with a fix, every 15 s without.
// - Selected position reports are sent once per second epoch.
// - Selected velocity reports are sent once per second epoch.
// - Health and machine status reports are sent every 30 seconds.
// - Differential fix mode report every 30 s, only in differential mode.
// - Host writes report-option bits; the scheduler applies them.
// - Byte0 bit0 selects XYZ position, bit4 picks double precision.
// - Byte0 bit1 selects LLA position, bit4 picks double precision.
// - Byte1 bit0 selects ECEF velocity, byte1 bit1 selects ENU velocity.
// - Byte0 bit5 selects UTM position by precision plus combined report.
// - Power-up order: health, status, position, velocity, time, diff mode.
// - Power-up ends after diff mode report; commands accepted only after.
// - Power-up time report only when GPS time is known.
// - Satellite data load subcodes 02 to 05 name the data loaded.
// - Correction data request is answered with the correction report.
// - Correction inputs of types 1, 9 and 2 are taken silently.
// - Time request gets time report; UTC request gets UTC report.
// - Packets are framed by control characters at start and end.
// - Each packet carries an identifier byte defining its contents.
package report_sched_pkg;

   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned EPOCH_S        = 1;
   localparam int unsigned EPOCH_CYCLES   = CLK_HZ * EPOCH_S;
   localparam int unsigned TIME_FIX_S     = 150;
   localparam int unsigned TIME_NOFIX_S   = 15;
   localparam int unsigned HEALTH_S       = 30;
   localparam int unsigned DIFF_S         = 30;

   // APB byte addresses
   localparam logic [7:0] OPT_ADDR    = 8'h00;
   localparam logic [7:0] CTRL_ADDR   = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;

   // Option word: byte 0 in [7:0], byte 1 in [15:8]
   localparam int unsigned OPT_XYZ_BIT   = 0;
   localparam int unsigned OPT_LLA_BIT   = 1;
   localparam int unsigned OPT_DBL_BIT   = 4;
   localparam int unsigned OPT_UTM_BIT   = 5;
   localparam int unsigned OPT_VECEF_BIT = 8;
   localparam int unsigned OPT_VENU_BIT  = 9;
   localparam logic [15:0] OPT_RESET     = 16'h0203;

   localparam int unsigned CTRL_FIX_BIT  = 0;
   localparam int unsigned CTRL_TIME_BIT = 1;
   localparam int unsigned CTRL_DIFF_BIT = 2;

   // Identifier bytes
   localparam logic [7:0] ID_TIME     = 8'h41;
   localparam logic [7:0] ID_XYZ_S    = 8'h42;
   localparam logic [7:0] ID_VECEF    = 8'h43;
   localparam logic [7:0] ID_HEALTH   = 8'h46;
   localparam logic [7:0] ID_LLA_S    = 8'h4a;
   localparam logic [7:0] ID_STATUS   = 8'h4b;
   localparam logic [7:0] ID_VENU     = 8'h56;
   localparam logic [7:0] ID_SATDATA  = 8'h58;
   localparam logic [7:0] ID_DIFFMODE = 8'h82;
   localparam logic [7:0] ID_XYZ_D    = 8'h83;
   localparam logic [7:0] ID_LLA_D    = 8'h84;
   localparam logic [7:0] ID_CORR     = 8'h85;
   localparam logic [7:0] ID_SUPER    = 8'h8f;
   localparam logic [7:0] SUB_UTM_S   = 8'h17;
   localparam logic [7:0] SUB_UTM_D   = 8'h18;
   localparam logic [7:0] SUB_COMBO   = 8'h20;
   localparam logic [7:0] SUB_NONE    = 8'h00;

   // Command identifiers
   localparam logic [7:0] CMD_TIME_REQ = 8'h21;
   localparam logic [7:0] CMD_SATLOAD  = 8'h38;
   localparam logic [7:0] CMD_CORR_19  = 8'h60;
   localparam logic [7:0] CMD_CORR_2   = 8'h61;
   localparam logic [7:0] CMD_CORR_REQ = 8'h65;
   localparam logic [7:0] SUB_ALMANAC  = 8'h02;
   localparam logic [7:0] SUB_ALM_HLTH = 8'h03;
   localparam logic [7:0] SUB_IONO     = 8'h04;
   localparam logic [7:0] SUB_UTC      = 8'h05;

   // Due-report slots, one bit each, sent lowest index first
   localparam int unsigned NSLOT        = 15;
   localparam int unsigned SL_HEALTH    = 0;
   localparam int unsigned SL_STATUS    = 1;
   localparam int unsigned SL_XYZ       = 2;
   localparam int unsigned SL_LLA       = 3;
   localparam int unsigned SL_UTM       = 4;
   localparam int unsigned SL_COMBO     = 5;
   localparam int unsigned SL_VECEF     = 6;
   localparam int unsigned SL_VENU      = 7;
   localparam int unsigned SL_TIME      = 8;
   localparam int unsigned SL_DIFF      = 9;
   localparam int unsigned SL_R_TIME    = 10;
   localparam int unsigned SL_R_UTC     = 11;
   localparam int unsigned SL_R_CORR    = 12;
   localparam int unsigned SL_SPARE0    = 13;
   localparam int unsigned SL_SPARE1    = 14;

   typedef enum logic [1:0] {ST_POWERUP, ST_RUN} phase_type;

   typedef struct packed {
      logic [7:0] id;
      logic [7:0] sub;
   } report_type;

   typedef struct packed {
      logic [7:0] id;
      logic [7:0] sub;
   } command_type;

endpackage

// ### logic/report_sched.sv
/*
 * Report scheduler: keeps the one-second epoch, raises due reports,
 * answers host commands and hands one report at a time to a framer.
 * Assumes a downstream framer adds the delimiters and payload and holds
 * rpt_ready low while a packet is on the wire; commands arrive parsed.
 */
`timescale 1ns/1ps
module report_sched #(
   parameter int unsigned EPOCH_CYCLES = report_sched_pkg::EPOCH_CYCLES
) (
   input  wire logic                        mclk,
   input  wire logic                        arst_n,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        diag_done,
   input  wire logic                        cmd_valid,
   input  wire report_sched_pkg::command_type cmd,
   output logic                             cmd_ready,
   output logic                             rpt_valid,
   output report_sched_pkg::report_type     rpt,
   input  wire logic                        rpt_ready,
   output logic                             epoch_tick,
   output logic                             powerup_done
);

   typedef struct packed {
      report_sched_pkg::phase_type phase;
      logic [31:0]                 epoch_cnt;
      logic [7:0]                  time_sec;
      logic [4:0]                  health_sec;
      logic [4:0]                  diff_sec;
      logic [15:0]                 opt;
      logic [2:0]                  ctrl;
      logic [report_sched_pkg::NSLOT-1:0] due;
      logic                        busy;
      report_sched_pkg::report_type out;
      logic [31:0]                 rdata;
      logic                        tick;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   logic                                 bus_access;
   logic                                 have_fix;
   logic                                 time_known;
   logic                                 diff_mode;
   logic [report_sched_pkg::NSLOT-1:0]   pick;
   logic [report_sched_pkg::NSLOT-1:0]   epoch_due;
   logic                                 time_due;
   report_sched_pkg::report_type         pick_rpt;

   assign bus_access = psel && penable;
   assign have_fix   = s_r.ctrl[report_sched_pkg::CTRL_FIX_BIT];
   assign time_known = s_r.ctrl[report_sched_pkg::CTRL_TIME_BIT];
   assign diff_mode  = s_r.ctrl[report_sched_pkg::CTRL_DIFF_BIT];

   // Lowest set slot wins, which fixes the output order
   assign pick = s_r.due & (~s_r.due + 15'h0001);

   always_comb begin
      pick_rpt = '{id: 8'h00, sub: report_sched_pkg::SUB_NONE};
      unique case (1'b1)
         pick[report_sched_pkg::SL_HEALTH]: pick_rpt.id = report_sched_pkg::ID_HEALTH;
         pick[report_sched_pkg::SL_STATUS]: pick_rpt.id = report_sched_pkg::ID_STATUS;
         pick[report_sched_pkg::SL_XYZ]:
            pick_rpt.id = s_r.opt[report_sched_pkg::OPT_DBL_BIT] ?
                          report_sched_pkg::ID_XYZ_D : report_sched_pkg::ID_XYZ_S;
         pick[report_sched_pkg::SL_LLA]:
            pick_rpt.id = s_r.opt[report_sched_pkg::OPT_DBL_BIT] ?
                          report_sched_pkg::ID_LLA_D : report_sched_pkg::ID_LLA_S;
         pick[report_sched_pkg::SL_UTM]: begin
            pick_rpt.id  = report_sched_pkg::ID_SUPER;
            pick_rpt.sub = s_r.opt[report_sched_pkg::OPT_DBL_BIT] ?
                           report_sched_pkg::SUB_UTM_D : report_sched_pkg::SUB_UTM_S;
         end
         pick[report_sched_pkg::SL_COMBO]: begin
            pick_rpt.id  = report_sched_pkg::ID_SUPER;
            pick_rpt.sub = report_sched_pkg::SUB_COMBO;
         end
         pick[report_sched_pkg::SL_VECEF]: pick_rpt.id = report_sched_pkg::ID_VECEF;
         pick[report_sched_pkg::SL_VENU]:  pick_rpt.id = report_sched_pkg::ID_VENU;
         pick[report_sched_pkg::SL_TIME],
         pick[report_sched_pkg::SL_R_TIME]: pick_rpt.id = report_sched_pkg::ID_TIME;
         pick[report_sched_pkg::SL_DIFF]: pick_rpt.id = report_sched_pkg::ID_DIFFMODE;
         pick[report_sched_pkg::SL_R_UTC]: begin
            pick_rpt.id  = report_sched_pkg::ID_SATDATA;
            pick_rpt.sub = report_sched_pkg::SUB_UTC;
         end
         pick[report_sched_pkg::SL_R_CORR]: pick_rpt.id = report_sched_pkg::ID_CORR;
         default: pick_rpt = '{id: 8'h00, sub: report_sched_pkg::SUB_NONE};
      endcase
   end

   // Position and velocity slots for this epoch, from the option word
   always_comb begin
      epoch_due = '0;
      epoch_due[report_sched_pkg::SL_XYZ]   =
         s_r.opt[report_sched_pkg::OPT_XYZ_BIT];
      epoch_due[report_sched_pkg::SL_LLA]   =
         s_r.opt[report_sched_pkg::OPT_LLA_BIT];
      epoch_due[report_sched_pkg::SL_UTM]   =
         s_r.opt[report_sched_pkg::OPT_UTM_BIT];
      epoch_due[report_sched_pkg::SL_COMBO] =
         s_r.opt[report_sched_pkg::OPT_UTM_BIT];
      epoch_due[report_sched_pkg::SL_VECEF] =
         s_r.opt[report_sched_pkg::OPT_VECEF_BIT];
      epoch_due[report_sched_pkg::SL_VENU]  =
         s_r.opt[report_sched_pkg::OPT_VENU_BIT];
   end

   // Interval follows the fix state at the moment of each epoch
   assign time_due = have_fix ?
      (s_r.time_sec >= 8'(report_sched_pkg::TIME_FIX_S - 1)) :
      (s_r.time_sec >= 8'(report_sched_pkg::TIME_NOFIX_S - 1));

   always_comb begin
      s_nxt      = s_r;
      s_nxt.tick = 1'b0;

      // Report hand-off; slot cleared when its report is loaded for the framer
      if (s_r.busy && rpt_ready) begin
         s_nxt.busy = 1'b0;
      end
      if (!s_r.busy && (s_r.due != '0)) begin
         s_nxt.busy = 1'b1;
         s_nxt.out  = pick_rpt;
         s_nxt.due  = s_r.due & ~pick;
      end

      unique case (s_r.phase)
         report_sched_pkg::ST_POWERUP: begin
            // Sequence loaded once diagnostics finish
            if (diag_done && s_r.due == '0 && !s_r.busy && s_r.epoch_cnt == '0) begin
               s_nxt.due = epoch_due;
               s_nxt.due[report_sched_pkg::SL_HEALTH] = 1'b1;
               s_nxt.due[report_sched_pkg::SL_STATUS] = 1'b1;
               s_nxt.due[report_sched_pkg::SL_TIME]   = time_known;
               s_nxt.due[report_sched_pkg::SL_DIFF]   = 1'b1;
               s_nxt.epoch_cnt = 32'h0000_0001;
            end
            if (s_r.epoch_cnt != '0 && s_r.busy && rpt_ready &&
                s_r.out.id == report_sched_pkg::ID_DIFFMODE) begin
               s_nxt.phase     = report_sched_pkg::ST_RUN;
               s_nxt.epoch_cnt = '0;
            end
         end
         report_sched_pkg::ST_RUN: begin
            // Free-running epoch, no host input needed
            if (s_r.epoch_cnt == 32'(EPOCH_CYCLES - 1)) begin
               s_nxt.epoch_cnt  = '0;
               s_nxt.tick       = 1'b1;
               s_nxt.due        = s_nxt.due | epoch_due;
               s_nxt.time_sec   = time_due ? 8'h00 : s_r.time_sec + 8'h01;
               s_nxt.health_sec = (s_r.health_sec == 5'(report_sched_pkg::HEALTH_S - 1)) ?
                                  5'h00 : s_r.health_sec + 5'h01;
               s_nxt.diff_sec   = (s_r.diff_sec == 5'(report_sched_pkg::DIFF_S - 1)) ?
                                  5'h00 : s_r.diff_sec + 5'h01;
               if (time_due) begin
                  s_nxt.due[report_sched_pkg::SL_TIME] = 1'b1;
               end
               if (s_r.health_sec == 5'(report_sched_pkg::HEALTH_S - 1)) begin
                  s_nxt.due[report_sched_pkg::SL_HEALTH] = 1'b1;
                  s_nxt.due[report_sched_pkg::SL_STATUS] = 1'b1;
               end
               if (s_r.diff_sec == 5'(report_sched_pkg::DIFF_S - 1) && diff_mode) begin
                  s_nxt.due[report_sched_pkg::SL_DIFF] = 1'b1;
               end
            end else begin
               s_nxt.epoch_cnt = s_r.epoch_cnt + 32'h0000_0001;
            end
            // Requests queue a reply slot; set joins after hand-off clear
            if (cmd_valid) begin
               unique case (cmd.id)
                  report_sched_pkg::CMD_TIME_REQ:
                     s_nxt.due[report_sched_pkg::SL_R_TIME] = 1'b1;
                  report_sched_pkg::CMD_SATLOAD:
                     if (cmd.sub == report_sched_pkg::SUB_UTC) begin
                        s_nxt.due[report_sched_pkg::SL_R_UTC] = 1'b1;
                     end
                  report_sched_pkg::CMD_CORR_REQ:
                     s_nxt.due[report_sched_pkg::SL_R_CORR] = 1'b1;
                  default: ;
               endcase
            end
         end
         default: s_nxt.phase = report_sched_pkg::ST_POWERUP;
      endcase

      // Register writes steer the scheduler
      s_nxt.rdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            report_sched_pkg::OPT_ADDR:  s_nxt.rdata = {16'h0000, s_r.opt};
            report_sched_pkg::CTRL_ADDR: s_nxt.rdata = {29'h0000_0000, s_r.ctrl};
            report_sched_pkg::STATUS_ADDR:
               s_nxt.rdata = {s_r.time_sec, s_r.busy,
                              7'(s_r.phase == report_sched_pkg::ST_RUN),
                              1'b0, s_r.due};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (bus_access && pwrite) begin
         if (paddr == report_sched_pkg::OPT_ADDR) begin
            s_nxt.opt = pwdata[15:0];
         end
         if (paddr == report_sched_pkg::CTRL_ADDR) begin
            s_nxt.ctrl = pwdata[2:0];
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_r            <= '0;
         s_r.phase      <= report_sched_pkg::ST_POWERUP;
         s_r.opt        <= report_sched_pkg::OPT_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pready       = 1'b1;
   assign prdata       = s_r.rdata;
   assign pslverr      = bus_access && (paddr != report_sched_pkg::OPT_ADDR) &&
                         (paddr != report_sched_pkg::CTRL_ADDR) &&
                         (paddr != report_sched_pkg::STATUS_ADDR);
   // Commands held off until the power-up run is over
   assign cmd_ready    = (s_r.phase == report_sched_pkg::ST_RUN);
   assign rpt_valid    = s_r.busy;
   // Whole report handed over at once; framer adds the delimiters
   assign rpt          = s_r.out;
   assign epoch_tick   = s_r.tick;
   assign powerup_done = (s_r.phase == report_sched_pkg::ST_RUN);

endmodule

// ### bench/report_sched_assertions.sv
/* Port checker for the report scheduler.
   Bound from the bench top; sees only the scheduler's ports. */
`timescale 1ns/1ps
module report_sched_assertions #(
   parameter int unsigned EPOCH_CYCLES = 50
) (
   input wire logic                          mclk,
   input wire logic                          arst_n,
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic                          pwrite,
   input wire logic [7:0]                    paddr,
   input wire logic [31:0]                   pwdata,
   input wire logic [31:0]                   prdata,
   input wire logic                          pready,
   input wire logic                          pslverr,
   input wire logic                          diag_done,
   input wire logic                          cmd_valid,
   input wire report_sched_pkg::command_type cmd,
   input wire logic                          cmd_ready,
   input wire logic                          rpt_valid,
   input wire report_sched_pkg::report_type  rpt,
   input wire logic                          rpt_ready,
   input wire logic                          epoch_tick,
   input wire logic                          powerup_done
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   logic [31:0] gap_r;
   logic        seen_r;
   logic        diff_r;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         gap_r  <= 32'h0000_0000;
         seen_r <= 1'b0;
         diff_r <= 1'b0;
      end else begin
         diff_r <= rpt_valid && rpt_ready && rpt.id == report_sched_pkg::ID_DIFFMODE;
         gap_r  <= epoch_tick ? 32'h0000_0000 : gap_r + 32'h0000_0001;
         seen_r <= seen_r | epoch_tick;
      end
   end
   sequence take_s;
      rpt_valid && rpt_ready;
   endsequence
   sequence diff_taken_s;
      take_s ##0 rpt.id == report_sched_pkg::ID_DIFFMODE;
   endsequence
   a_ready_gate: assert property ($rose(cmd_ready) |-> diff_r)
      else $error("commands accepted before diff mode report");
   a_done_on_diff: assert property (diff_taken_s ##0 !powerup_done |=> powerup_done)
      else $error("power-up not done after diff mode report");
   a_done_not_early: assert property ($rose(powerup_done) |-> diff_r)
      else $error("power-up done without diff mode report");
   a_no_early_tick: assert property (!powerup_done |-> !epoch_tick)
      else $error("epoch tick during power-up");
   a_first_health: assert property ($rose(diag_done) && !powerup_done |-> ##[1:3]
      (rpt_valid && rpt.id == report_sched_pkg::ID_HEALTH))
      else $error("power-up does not open with health report");
   a_report_hold: assert property (rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt))
      else $error("report dropped or changed before take");
   a_gap_after_take: assert property (take_s |=> !rpt_valid)
      else $error("no idle cycle after report take");
   a_epoch_period: assert property (epoch_tick && seen_r |-> gap_r == EPOCH_CYCLES - 1)
      else $error("epoch period wrong");
   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("register access not zero wait");
   a_unmapped_err: assert property (psel && penable |-> pslverr == !(paddr inside {8'h00,
      8'h04, 8'h08}))
      else $error("error response wrong for address");
   a_time_reply: assert property (cmd_valid && cmd_ready && cmd.id == report_sched_pkg::
      CMD_TIME_REQ |=> ##[0:40] (rpt_valid && rpt.id == report_sched_pkg::ID_TIME))
      else $error("time request not answered");
   a_corr_reply: assert property (cmd_valid && cmd_ready && cmd.id == report_sched_pkg::
      CMD_CORR_REQ |=> ##[0:40] (rpt_valid && rpt.id == report_sched_pkg::ID_CORR))
      else $error("correction request not answered");
endmodule

// ### bench/host_framer.sv
/* Host-side framer model: takes reports off the scheduler, stalling at random.
   Assumes the bench seeds the random generator once. */
`timescale 1ns/1ps
module host_framer (
   input wire logic                         mclk,
   input wire logic                         arst_n,
   input wire logic                         slow,
   input wire logic                         rpt_valid,
   input wire report_sched_pkg::report_type rpt,
   output logic                             rpt_ready,
   output logic                             got_valid,
   output report_sched_pkg::report_type     got
);
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rpt_ready <= 1'b0;
         got_valid <= 1'b0;
         got       <= 16'h0000;
      end else begin
         // Whole report captured in one cycle on each take, no delimiters
         got_valid <= rpt_valid && rpt_ready;
         if (rpt_valid && rpt_ready) got <= rpt;
         // Slow mode busy half the time, as a real link would be
         rpt_ready <= slow ? $urandom_range(1, 0) == 1 : 1'b1;
      end
   end
endmodule

// ### bench/test_report_sched.sv
/* Self-checking bench of the report scheduler with a queue model of the
   expected report stream. Assumes EPOCH_CYCLES shortened to 50. */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_report_sched;
   logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, diag_done, cmd_valid, cmd_ready;
   logic rpt_valid, rpt_ready, epoch_tick, powerup_done, slow, got_valid, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   report_sched_pkg::command_type cmd;
   report_sched_pkg::report_type rpt, got, e;
   report_sched_pkg::report_type exp_q[$];
   logic [15:0] opt_s;
   logic [2:0] ctrl_s;
   int failures, checks_done, n_ep;
   logic [15:0] cmds[8] = '{16'h2100, 16'h3805, 16'h6500, 16'h6000, 16'h6100, 16'h3802,
                            16'h3803, 16'h3804};
   report_sched #(.EPOCH_CYCLES(50)) i_report_sched (.mclk(mclk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .diag_done(diag_done),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rpt_valid(rpt_valid),
      .rpt(rpt), .rpt_ready(rpt_ready), .epoch_tick(epoch_tick), .powerup_done(powerup_done));
   host_framer i_host_framer (.mclk(mclk), .arst_n(arst_n), .slow(slow), .rpt_valid(rpt_valid),
      .rpt(rpt), .rpt_ready(rpt_ready), .got_valid(got_valid), .got(got));
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;
   function automatic void push(input logic [7:0] id, input logic [7:0] sub);
      exp_q.push_back({id, sub});
   endfunction
   function automatic void push_pv();
      if (opt_s[0]) push(opt_s[4] ? 8'h83 : 8'h42, 8'h00);
      if (opt_s[1]) push(opt_s[4] ? 8'h84 : 8'h4a, 8'h00);
      if (opt_s[5]) push(8'h8f, opt_s[4] ? 8'h18 : 8'h17);
      if (opt_s[5]) push(8'h8f, 8'h20);
      if (opt_s[8]) push(8'h43, 8'h00);
      if (opt_s[9]) push(8'h56, 8'h00);
   endfunction
   always @(posedge mclk) begin
      if (arst_n && epoch_tick === 1'b1) begin
         n_ep = n_ep + 1;
         if (n_ep % 30 == 0) begin
            push(8'h46, 8'h00);
            push(8'h4b, 8'h00);
         end
         push_pv();
         if (n_ep % (ctrl_s[0] ? 150 : 15) == 0) push(8'h41, 8'h00);
         if (ctrl_s[2] && n_ep % 30 == 0) push(8'h82, 8'h00);
      end
      if (got_valid === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
         `CHK(got, e)
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_on(input int limit, ref logic flag);
      int w;
      w = 0;
      while (flag !== 1'b1 && w < limit) begin
         @(posedge mclk);
         w++;
      end
      `CHK(flag, 1'b1)
   endtask
   task automatic phase(input logic [2:0] c, input int k);
      int w;
      arst_n <= 1'b0;
      diag_done <= 1'b0;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      n_ep = 0;
      opt_s = 16'h0203;
      ctrl_s = c;
      exp_q.delete();
      apb(1'b0, 8'h00, 32'h0000_0000);
      `CHK({err, rdat}, {1'b0, 32'h0000_0203})
      apb(1'b0, 8'h0c, 32'h0000_0000);
      `CHK({err, rdat}, {1'b1, 32'h0000_0000})
      apb(1'b1, 8'h04, {29'h0000_0000, c});
      apb(1'b0, 8'h04, 32'h0000_0000);
      `CHK(rdat, {29'h0000_0000, c})
      cmd_valid <= 1'b1;
      cmd <= 16'h2100;
      @(posedge mclk);
      `CHK(cmd_ready, 1'b0)
      cmd_valid <= 1'b0;
      push(8'h46, 8'h00);
      push(8'h4b, 8'h00);
      push_pv();
      if (c[1]) push(8'h41, 8'h00);
      push(8'h82, 8'h00);
      diag_done <= 1'b1;
      wait_on(300, powerup_done);
      apb(1'b0, 8'h08, 32'h0000_0000);
      `CHK(rdat[16], 1'b1)
      for (int i = 0; i < k; i++) begin
         wait_on(200, epoch_tick);
         @(posedge mclk);
         w = 0;
         while (exp_q.size() > 0 && w < 60) begin
            @(posedge mclk);
            w++;
         end
         apb(1'b1, 8'h00, {16'h0000, 16'($urandom) & 16'h0333});
         opt_s = pwdata[15:0];
         // Host commands only after power-up; time, UTC and correction requests expect replies
         cmd_valid <= 1'b1;
         cmd <= cmds[i % 8];
         if (cmds[i % 8] == 16'h2100) push(8'h41, 8'h00);
         if (cmds[i % 8] == 16'h3805) push(8'h58, 8'h05);
         if (cmds[i % 8] == 16'h6500) push(8'h85, 8'h00);
         @(posedge mclk);
         cmd_valid <= 1'b0;
      end
      // Drain before the next epoch adds reports; silent commands get a few cycles
      w = 0;
      while ((exp_q.size() > 0 || w < 6) && w < 40) begin
         @(posedge mclk);
         w++;
      end
      `CHK(exp_q.size(), 0)
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge mclk);
      failures++;
      tally_and_finish();
   end
   initial begin
      {arst_n, psel, penable, pwrite, diag_done, cmd_valid, slow} = 7'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      cmd = 16'h0000;
      failures = 0;
      checks_done = 0;
      void'($urandom(91993));
      phase(3'h0, 31);
      slow <= 1'b1;
      phase(3'h7, 151);
      tally_and_finish();
   end
endmodule
bind report_sched report_sched_assertions #(.EPOCH_CYCLES(EPOCH_CYCLES)) i_report_sched_assertions (
   .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .diag_done(diag_done), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
   .rpt_valid(rpt_valid), .rpt(rpt), .rpt_ready(rpt_ready), .epoch_tick(epoch_tick),
   .powerup_done(powerup_done));
